/* File: include/oc_pulse_pkg.sv */
// Constants, types and register layout for the output compare channel.
// Assumes a 32-bit APB slave port and external 16-bit time bases.
//
// Overview of operation
// (RULE_01) Software picks single-shot or continuous pulses
// (RULE_02) Toggle mode inverts pin on every match
// (RULE_03) Edge counts measured upward from zero
// (RULE_04) Software loads both compare values first
// (RULE_05) Trigger enable picks triggered or synchronous start
// (RULE_06) Trigger status holds hardware or software trigger
// (RULE_07) Sync select zero means free running
// (RULE_08) Software selects time base before enabling
// (RULE_09) Sync starts at once, trigger waits event
// (RULE_10) Compare modes have mode MSB clear
// (RULE_11) Cascade bit 8 set, even channel first
// (RULE_12) Even channel of cascade stays synchronous
// (RULE_13) Cascade pin set up on even channel
// (RULE_14) Trigger enable 7, status 6, sync 4:0
// (RULE_15) Cascade modes written even channel first
// (RULE_16) Pin leaves default level on primary match
// (RULE_17) Pin returns to default on secondary match
// (RULE_18) Flag on primary or secondary match per mode
// (RULE_19) Single shot fires once, control write re-arms
// (RULE_20) Continuous pulses run until mode changes; here they also stop, back to wait, when the start condition drops
// (RULE_21) Match checked every increment, acted within clock
package oc_pulse_pkg;

   // =====================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CON1 = 8'h00; // Mode, time base
   localparam logic [7:0] OFF_CON2 = 8'h04; // Trigger, sync
   localparam logic [7:0] OFF_PRI  = 8'h08; // Primary compare
   localparam logic [7:0] OFF_SEC  = 8'h0c; // Secondary compare
   localparam logic [7:0] OFF_STAT = 8'h10; // Flag and state
   localparam logic [7:0] OFF_PRIO = 8'h14; // Priority bits

   // =====================================================
   // Field positions
   localparam int MODE_LSB  = 0;  // compare_mode_select 2:0
   localparam int TBSEL_LSB = 10; // time_base_select 12:10
   localparam int SYNC_LSB  = 0;  // sync_source_select 4:0
   localparam int TRIS_BIT  = 5;  // output_tristate
   localparam int TSTAT_BIT = 6;  // trigger_status
   localparam int TRIGEN_BIT = 7; // trigger_enable
   localparam int CASC_BIT  = 8;  // cascade_enable
   localparam int TMODE_BIT = 15; // trigger_behaviour_mode
   localparam int FLAG_BIT  = 0;  // compare_interrupt_flag
   localparam int PIN_BIT   = 1;  // Pin level
   localparam int STATE_LSB = 2;  // Channel state 3:2
   localparam int T4P_LSB   = 12; // timer4_irq_priority
   localparam int C3P_LSB   = 4;  // channel3_irq_priority

   // =====================================================
   // Reset values
   localparam logic [15:0] PRIO_RESET = 16'h4040;
   localparam logic [4:0]  SYNC_NONE  = 5'h00;

   // Compare modes; codes with MSB set are not compare
   typedef enum logic [2:0] {
      MODE_OFF     = 3'b000,
      MODE_TOGGLE  = 3'b001,
      MODE_ONESHOT = 3'b010,
      MODE_CONT    = 3'b011
   } cmp_mode_t;

   // Channel sequencing states
   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10,
      ST_DONE = 2'b11
   } chan_state_t;

   // One time base: count and its increment strobe
   typedef struct packed {
      logic        tick;
      logic [15:0] count;
   } time_base_t;

endpackage : oc_pulse_pkg

/* File: design/output_compare_pulse_unit.sv */
// Output compare channel with APB register access.
// Assumes time bases and sync sources are synchronous to mclk.
`timescale 1ns/1ps
module output_compare_pulse_unit #(
   parameter int NUM_TB = 8 // Number of selectable time bases
) (
   input  wire logic                   mclk,
   input  wire logic                   srst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  oc_pulse_pkg::time_base_t    timeBase [NUM_TB],
   input  wire logic [31:0]            syncSrc,
   output logic                        compOut,
   output logic                        compOutEn,
   output logic                        compareFlag
);

   // =====================================================
   // Parameter check
   // Select field is three bits, so more bases are unreachable
   if (NUM_TB < 1 || NUM_TB > 8) begin : badTb
      $error("NUM_TB must be 1 to 8");
   end

   // =====================================================
   // Control state
   logic [2:0]  mode;        // compare_mode_select
   logic [2:0]  tbSel;       // time_base_select
   logic [4:0]  syncSel;     // sync_source_select
   logic        tristate;    // output_tristate
   logic        trigStatus;  // trigger_status
   logic        trigEn;      // trigger_enable
   logic        cascade;     // cascade_enable
   logic        trigger_behaviour_mode;    // trigger_behaviour_mode
   logic [15:0] priVal;      // primary_compare_value
   logic [15:0] secVal;      // secondary_compare_value
   logic [2:0]  t4Prio;      // timer4_irq_priority
   logic [2:0]  c3Prio;      // channel3_irq_priority
   logic        srcPrev;     // Sync source last cycle
   oc_pulse_pkg::chan_state_t state;
   oc_pulse_pkg::chan_state_t next_state;
   logic        next_pin;

   // =====================================================
   // APB decode
   wire logic access = psel & penable;         // Access phase
   wire logic setup  = psel & ~penable;        // Setup phase
   wire logic hitCon1 = (paddr == oc_pulse_pkg::OFF_CON1);
   wire logic hitCon2 = (paddr == oc_pulse_pkg::OFF_CON2);
   wire logic hitPri  = (paddr == oc_pulse_pkg::OFF_PRI);
   wire logic hitSec  = (paddr == oc_pulse_pkg::OFF_SEC);
   wire logic hitStat = (paddr == oc_pulse_pkg::OFF_STAT);
   wire logic hitPrio = (paddr == oc_pulse_pkg::OFF_PRIO);
   wire logic mapped = hitCon1 | hitCon2 | hitPri | hitSec
                       | hitStat | hitPrio;
   wire logic wrEn = access & pwrite & mapped; // Write commit
   wire logic con1Wr = wrEn & hitCon1;
   wire logic con2Wr = wrEn & hitCon2;

   // Zero wait states; read data is caught in setup
   assign pready  = 1'b1;
   // Unmapped offsets answer with an error
   assign pslverr = access & ~mapped;

   // =====================================================
   // Readback words
   logic [31:0] rdMux;
   wire logic [31:0] con1Word = {16'h0000, 3'h0,
      tbSel, 7'h00, mode};
   wire logic [31:0] con2Word = {16'h0000, trigger_behaviour_mode, 6'h00,
      cascade, trigEn, trigStatus, tristate, syncSel}; // RULE_14
   wire logic [31:0] statWord = {28'h0000000, state,
      compOut, compareFlag};
   wire logic [31:0] prioWord = {17'h00000, t4Prio, 5'h00,
      c3Prio, 4'h0};

   // Address select for reads
   always_comb begin
      if (hitCon1) begin
         rdMux = con1Word;
      end else if (hitCon2) begin
         rdMux = con2Word;
      end else if (hitPri) begin
         rdMux = {16'h0000, priVal};
      end else if (hitSec) begin
         rdMux = {16'h0000, secVal};
      end else if (hitStat) begin
         rdMux = statWord;
      end else if (hitPrio) begin
         rdMux = prioWord;
      end else begin
         rdMux = 32'h00000000;
      end
   end

   // Read data held in a flop, loaded in setup
   always_ff @(posedge mclk) begin
      if (srst) begin
         prdata <= 32'h00000000;
      end else if (setup & ~pwrite) begin
         prdata <= rdMux;
      end
   end

   // =====================================================
   // Time base and match detection
   // Out-of-range select reads as a stopped base
   wire oc_pulse_pkg::time_base_t selTb =
      (32'(tbSel) < NUM_TB) ? timeBase[tbSel] : '0;
   wire logic running = (state == oc_pulse_pkg::ST_RUN);
   // Counts run upward from zero, so equality is enough
   wire logic priMatch = running & selTb.tick
                         & (selTb.count == priVal); // RULE_03 RULE_21
   wire logic secMatch = running & selTb.tick
                         & (selTb.count == secVal); // RULE_21

   // Mode classes
   wire logic isToggle = (mode == oc_pulse_pkg::MODE_TOGGLE);
   wire logic isShot   = (mode == oc_pulse_pkg::MODE_ONESHOT);
   wire logic isCont   = (mode == oc_pulse_pkg::MODE_CONT);
   wire logic isDouble = isShot | isCont;
   // Mode MSB set is never a compare operation
   wire logic modeOn = ~mode[2]
                       & (mode != oc_pulse_pkg::MODE_OFF); // RULE_10

   // =====================================================
   // Start conditions
   wire logic srcLevel = syncSrc[syncSel];
   wire logic noSrc = (syncSel == oc_pulse_pkg::SYNC_NONE);
   // Hardware trigger is a rising edge of the source
   wire logic hwTrig = trigEn & ~noSrc & srcLevel & ~srcPrev;
   // Sync start follows the source; no source is free run
   wire logic syncGo = noSrc | srcLevel;              // RULE_07
   wire logic started = trigEn ? trigStatus : syncGo; // RULE_05
   // Trigger mode bit ends the trigger with each pulse
   wire logic autoClr = trigger_behaviour_mode & secMatch & isDouble;
   wire logic flagEvt = (isToggle & priMatch)
                        | (isDouble & secMatch);     // RULE_18
   wire logic flagClr = wrEn & hitStat & pwdata[oc_pulse_pkg::FLAG_BIT];

   // Edge memory for trigger detection
   // A source already high when reset ends is no edge, as reset clears trigEn and syncSel
   always_ff @(posedge mclk) begin
      if (srst) begin
         srcPrev <= 1'b0;
      end else begin
         srcPrev <= srcLevel;
      end
   end

   // =====================================================
   // Control registers
   // Software writes commit only at the access edge
   always_ff @(posedge mclk) begin
      if (srst) begin
         mode     <= 3'h0;
         tbSel    <= 3'h0;
         syncSel  <= 5'h00;
         tristate <= 1'b0;
         trigEn   <= 1'b0;
         cascade  <= 1'b0;
         trigger_behaviour_mode <= 1'b0;
      end else if (con1Wr) begin
         mode  <= pwdata[oc_pulse_pkg::MODE_LSB +: 3];  // RULE_01
         tbSel <= pwdata[oc_pulse_pkg::TBSEL_LSB +: 3];
      end else if (con2Wr) begin
         syncSel  <= pwdata[oc_pulse_pkg::SYNC_LSB +: 5];
         tristate <= pwdata[oc_pulse_pkg::TRIS_BIT];
         trigEn   <= pwdata[oc_pulse_pkg::TRIGEN_BIT];  // RULE_05
         cascade  <= pwdata[oc_pulse_pkg::CASC_BIT];
         trigger_behaviour_mode <= pwdata[oc_pulse_pkg::TMODE_BIT];   // RULE_06
      end
   end

   // Compare values and priority fields
   always_ff @(posedge mclk) begin
      if (srst) begin
         priVal <= 16'h0000;
         secVal <= 16'h0000;
         t4Prio <= oc_pulse_pkg::PRIO_RESET[oc_pulse_pkg::T4P_LSB +: 3];
         c3Prio <= oc_pulse_pkg::PRIO_RESET[oc_pulse_pkg::C3P_LSB +: 3];
      end else begin
         if (wrEn & hitPri) begin
            priVal <= pwdata[15:0];
         end
         if (wrEn & hitSec) begin
            secVal <= pwdata[15:0];
         end
         if (wrEn & hitPrio) begin
            t4Prio <= pwdata[oc_pulse_pkg::T4P_LSB +: 3];
            c3Prio <= pwdata[oc_pulse_pkg::C3P_LSB +: 3];
         end
      end
   end

   // Trigger status: hardware set beats any clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         trigStatus <= 1'b0;
      end else if (hwTrig) begin
         trigStatus <= 1'b1;                                // RULE_06
      end else if (con2Wr) begin
         trigStatus <= pwdata[oc_pulse_pkg::TSTAT_BIT];     // RULE_06
      end else if (autoClr) begin
         trigStatus <= 1'b0;
      end
   end

   // Flag: a match in the clearing cycle still sets it
   always_ff @(posedge mclk) begin
      if (srst) begin
         compareFlag <= 1'b0;
      end else if (flagEvt) begin
         compareFlag <= 1'b1;                               // RULE_18
      end else if (flagClr) begin
         compareFlag <= 1'b0;
      end
   end

   // =====================================================
   // Channel sequencer
   always_comb begin
      next_state = state;
      case (state)
         oc_pulse_pkg::ST_OFF: begin
            next_state = oc_pulse_pkg::ST_WAIT;
         end
         oc_pulse_pkg::ST_WAIT: begin
            if (started) begin
               next_state = oc_pulse_pkg::ST_RUN;           // RULE_09
            end
         end
         oc_pulse_pkg::ST_RUN: begin
            if (isShot & secMatch) begin
               next_state = oc_pulse_pkg::ST_DONE;          // RULE_19
            end else if (~started & ~autoClr) begin
               next_state = oc_pulse_pkg::ST_WAIT;
            end
         end
         default: begin
            next_state = oc_pulse_pkg::ST_DONE;             // RULE_19
         end
      endcase
      // A control write re-arms; continuous runs on while the start condition holds
      if (~modeOn | con1Wr) begin
         next_state = oc_pulse_pkg::ST_OFF;                 // RULE_20
      end
   end

   // Pin next value; secondary wins on equal counts
   always_comb begin
      next_pin = compOut;
      if (state == oc_pulse_pkg::ST_OFF) begin
         next_pin = 1'b0;                                   // RULE_16
      end else if (isToggle & priMatch) begin
         next_pin = ~compOut;                               // RULE_02
      end else if (isDouble & secMatch) begin
         next_pin = 1'b0;                                   // RULE_17
      end else if (isDouble & priMatch) begin
         next_pin = 1'b1;                                   // RULE_16
      end
   end

   // State and pin flops
   always_ff @(posedge mclk) begin
      if (srst) begin
         state   <= oc_pulse_pkg::ST_OFF;
         compOut <= 1'b0;
      end else begin
         state   <= next_state;
         compOut <= next_pin;
      end
   end

   // Pin driven unless software tristates it
   // Tristate only gates the pad; compare logic keeps running
   assign compOutEn = ~tristate;

   // =====================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   // Pin behaviour on matches
   pin_rise_a: assert property ( // RULE_16
      isDouble & priMatch & ~secMatch & modeOn & ~con1Wr |=> compOut)
      else $error("pin did not rise on primary match");
   pin_fall_a: assert property ( // RULE_17
      isDouble & secMatch & modeOn & ~con1Wr |=> ~compOut)
      else $error("pin did not fall on secondary match");
   pin_toggle_a: assert property ( // RULE_02
      isToggle & priMatch & modeOn & ~con1Wr |=> compOut != $past(compOut))
      else $error("toggle match left pin unchanged");
   flag_set_a: assert property (flagEvt |=> compareFlag) // RULE_18
      else $error("match did not set flag");
   shot_done_a: assert property ( // RULE_19
      state == oc_pulse_pkg::ST_DONE |-> ~compOut)
      else $error("pin high after single shot");
   // Start and trigger sequencing
   cont_run_a: assert property ( // RULE_20
      isCont & secMatch & started & modeOn & ~con1Wr
      |=> state == oc_pulse_pkg::ST_RUN)
      else $error("continuous pulse stopped");
   trig_wait_a: assert property ( // RULE_09
      trigEn & ~trigStatus & state == oc_pulse_pkg::ST_WAIT
      |=> state != oc_pulse_pkg::ST_RUN)
      else $error("triggered start without trigger");
   free_run_a: assert property ( // RULE_07
      noSrc & ~trigEn & modeOn & ~con1Wr & state == oc_pulse_pkg::ST_WAIT
      |=> state == oc_pulse_pkg::ST_RUN)
      else $error("free running start missed");
   non_compare_a: assert property ( // RULE_10
      mode[2] |=> state == oc_pulse_pkg::ST_OFF ##1 ~compOut)
      else $error("non compare mode kept running");
   hw_trig_a: assert property (hwTrig |=> trigStatus) // RULE_06
      else $error("hardware trigger lost");
   // Restart and idle behaviour of the pin
   control_rearm_a: assert property ( // RULE_19
      con1Wr |=> state == oc_pulse_pkg::ST_OFF)
      else $error("control write did not restart channel");
   off_pin_low_a: assert property ( // RULE_16
      state == oc_pulse_pkg::ST_OFF |=> ~compOut)
      else $error("pin not at default level when off");
   // Matches outside the run state must not move the pin
   idle_pin_hold_a: assert property ( // RULE_09
      ~running & state != oc_pulse_pkg::ST_OFF |=> $stable(compOut))
      else $error("pin moved outside run state");

   shot_cover_c: cover property (isShot & priMatch ##[1:1000]
      state == oc_pulse_pkg::ST_DONE);
   cont_cover_c: cover property (isCont & secMatch ##[1:1000]
      isCont & priMatch);
   trig_cover_c: cover property (hwTrig ##[1:20]
      state == oc_pulse_pkg::ST_RUN);
   toggle_cover_c: cover property (isToggle & priMatch ##1
      compOut);

endmodule : output_compare_pulse_unit

/* File: tb/time_base_model.sv */
// Partner model: eight upward counting time bases for the compare channel.
// Assumes the bench drives clear and run just after rising edges of mclk.
`timescale 1ns/1ps
module time_base_model (
   input  wire logic                mclk,
   input  wire logic                srst,
   input  wire logic                clear, // Restart every count at zero
   input  wire logic                run,   // Bases advance while high
   output oc_pulse_pkg::time_base_t base [8]
);
   logic [2:0] div [8]; // Prescale count per base

   // ==========================================================
   // Base i advances every i+1 cycles, so fast and slow bases exist;
   // a count holds between ticks, so a sloppy match fires repeatedly
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 8; i++) begin
         if (srst || clear) begin
            base[i] <= '0;
            div[i]  <= 3'h0;
         end else if (run && div[i] == 3'(i)) begin
            base[i].tick  <= 1'b1;
            base[i].count <= base[i].count + 16'h0001;
            div[i]        <= 3'h0;
         end else begin
            // Idle cycle: count stands, no tick
            base[i].tick <= 1'b0;
            div[i]       <= run ? div[i] + 3'h1 : div[i];
         end
      end
   end
endmodule : time_base_model

/* File: tb/output_compare_pulse_unit_test.sv */
// Self-checking bench for the output compare channel.
// Assumes zero wait state APB and the time base partner model.
`timescale 1ns/1ps
module output_compare_pulse_unit_test;
   localparam logic [7:0] CON1 = oc_pulse_pkg::OFF_CON1;
   localparam logic [7:0] CON2 = oc_pulse_pkg::OFF_CON2;
   localparam logic [7:0] STAT = oc_pulse_pkg::OFF_STAT;
   localparam logic [7:0] PRIO = oc_pulse_pkg::OFF_PRIO;
   typedef struct {logic pin; logic [15:0] cnt;} pin_note_t;

   logic mclk = 1'b0, srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, syncSrc = 32'h0, prdata;
   logic pready, pslverr, compOut, compOutEn, compareFlag;
   logic baseClear = 1'b0, baseRun = 1'b0, lastPin = 1'b0;
   logic [15:0] prevCnt = 16'h0;
   int selCur = 0, n_mismatch = 0, checks = 0;
   oc_pulse_pkg::time_base_t base [8];
   pin_note_t q [$]; // Expected pin edges, oldest first

   // ==========================================================
   // Clock, design and partner
   always #50 mclk = ~mclk;
   output_compare_pulse_unit #(.NUM_TB(8)) u_dut (.mclk(mclk),
      .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timeBase(base), .syncSrc(syncSrc),
      .compOut(compOut), .compOutEn(compOutEn),
      .compareFlag(compareFlag));
   time_base_model u_base (.mclk(mclk), .srst(srst), .clear(baseClear),
      .run(baseRun), .base(base));

   // ==========================================================
   // Compare and verdict
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // ==========================================================
   // APB master: holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // Only the watchdog ends a wait that never completes
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check("prdata", r, x);
      check("pslverr", {31'h0, e}, {31'h0, xe});
      check("pready", {31'h0, pready}, 32'h1);
      if (a == STAT) begin
         check("compareFlag", {31'h0, compareFlag}, {31'h0, x[0]});
      end
   endtask : rd

   // ==========================================================
   // Channel helpers; a CON1 write always restarts the channel
   task automatic arm(input logic [2:0] m, input int s,
                      input logic [15:0] p, input logic [15:0] sc);
      wr(oc_pulse_pkg::OFF_PRI, {16'h0, p});
      wr(oc_pulse_pkg::OFF_SEC, {16'h0, sc});
      wr(CON1, {19'h0, 3'(s), 7'h0, m});
      selCur = s;
   endtask : arm

   task automatic note(input logic pin, input logic [15:0] c);
      q.push_back('{pin, c});
   endtask : note

   // One timer period from zero; every noted edge must be seen
   task automatic burst(input int cyc);
      baseClear <= 1'b1;
      @(posedge mclk);
      baseClear <= 1'b0;
      baseRun   <= 1'b1;
      repeat (cyc) @(posedge mclk);
      baseRun   <= 1'b0;
      @(posedge mclk);
      check("pending", 32'(q.size()), 32'h0);
   endtask : burst

   task automatic pulse(input int s, input logic [15:0] p, sc);
      note(1'b1, p);
      note(1'b0, sc);
      burst((s + 1) * (sc + 3));
   endtask : pulse

   // ==========================================================
   // Watcher: each pin edge takes the oldest note
   always @(posedge mclk) begin
      pin_note_t n;
      #1;
      if (compOut !== lastPin) begin
         n = (q.size() > 0) ? q.pop_front() : '{~compOut, 16'hffff};
         check("compOut", {31'h0, compOut}, {31'h0, n.pin});
         check("matchCount", {16'h0, prevCnt}, {16'h0, n.cnt});
      end
      lastPin = compOut;
      prevCnt = base[selCur].count;
   end

   // Watchdog far beyond the at most 1400 or so cycles of the tests
   initial begin
      repeat (30000) @(posedge mclk);
      n_mismatch++;
      print_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] v;
      int s;
      logic [15:0] p, sc;
      void'($urandom(47726));
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      // Register table and unmapped access
      rd(PRIO, 32'h4040, 1'b0);
      rd(8'h18, 32'h0, 1'b1);
      v = $urandom & 32'h7070;
      wr(PRIO, v);
      rd(PRIO, v, 1'b0);
      v = $urandom & 32'h81ff;
      wr(CON2, v);
      rd(CON2, v, 1'b0);
      check("compOutEn", {31'h0, compOutEn}, {31'h0, ~v[5]});
      // Cascade set up: bit 8 on, trigger off, pin forced to output
      wr(CON2, 32'h100);
      rd(CON2, 32'h100, 1'b0);
      check("compOutEn", {31'h0, compOutEn}, 32'h1);
      wr(CON1, 32'h0);
      wr(CON2, 32'h0);
      // Single shot on a random base, fires once, re-armed by CON1
      s = $urandom % 8;
      p = 16'(2 + $urandom % 20);
      sc = p + 16'(1 + $urandom % 10);
      arm(3'h2, s, p, sc);
      pulse(s, p, sc);
      rd(STAT, 32'hd, 1'b0);
      wr(STAT, 32'h1);
      burst((s + 1) * (sc + 3));
      rd(STAT, 32'hc, 1'b0);
      arm(3'h2, s, p, sc);
      pulse(s, p, sc);
      // Continuous pulses until the mode changes
      arm(3'h3, 1, 16'h4, 16'h8);
      for (int k = 0; k < 3; k++) begin
         pulse(1, 16'h4, 16'h8);
      end
      rd(STAT, 32'h9, 1'b0);
      wr(CON1, 32'h0);
      burst(30);
      // Toggle: flag on primary match
      wr(STAT, 32'h1);
      arm(3'h1, 0, 16'h4, 16'h9);
      note(1'b1, 16'h4);
      burst(20);
      rd(STAT, 32'hb, 1'b0);
      note(1'b0, 16'h4);
      burst(20);
      // Codes with the top mode bit set leave the channel off
      wr(STAT, 32'h1);
      for (int m = 4; m < 8; m++) begin
         arm(3'(m), 0, 16'h3, 16'h6);
         burst(20);
         rd(STAT, 32'h0, 1'b0);
      end
      // Hardware trigger, software trigger, then sync source
      for (int k = 0; k < 3; k++) begin
         wr(STAT, 32'h1);
         wr(CON2, (k < 2) ? 32'h83 : 32'h2);
         arm(3'h2, 0, 16'h3, 16'h6);
         burst(20);
         rd(STAT, 32'h4, 1'b0);
         if (k == 1) begin
            wr(CON2, 32'hc3);
         end else begin
            syncSrc[3 - k / 2] <= 1'b1;
         end
         repeat (3) @(posedge mclk);
         rd(STAT, 32'h8, 1'b0);
         pulse(0, 16'h3, 16'h6);
         syncSrc <= 32'h0;
      end
      print_verdict();
   end
endmodule : output_compare_pulse_unit_test
